// ===== rtl/commutation_logic.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - mode code 010 selects pattern commutation
// - diode recirculation keeps modulated low sides off
// - reference input sets duty and frequency
// - three aux inputs pick pattern state
// - pattern mode ignores fourth aux input
// - step low six-step, high advanced pattern
// - step low codes map to six states
// - step high codes give advanced states
// - 111 aligns, 000 stops all gates
// - active freewheel drives inverted modulation low
// - brake request overrides every commutation state
// - brake styles: low, high, alternate, off
// - mode code 011 selects hall commutation
// - hall uses aux 1,3,4 plus direction
// - hall direction high commutation table
// - hall direction low commutation table
// - hall codes 111 and 000 force off
// - hall mode honours recirculation select too
// - dead time between complementary gate commands
module commutation_logic #(
  parameter int DT_W = 8
) (
  input wire logic clk_i, // 125 MHz clock
  input wire logic rst_i, // sync reset, high
  input wire logic duty_reference_input_i, // pwm reference
  input wire logic aux_input_1_i, // pattern / hall a
  input wire logic aux_input_2_i, // pattern bit
  input wire logic aux_input_3_i, // pattern / hall b
  input wire logic aux_input_4_i, // hall c
  input wire logic step_direction_input_i, // 12-step / direction
  input wire logic brake_request_n_i, // brake, low active
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  output logic gate_high_a_o, // phase a high gate
  output logic gate_low_a_o, // phase a low gate
  output logic gate_high_b_o, // phase b high gate
  output logic gate_low_b_o, // phase b low gate
  output logic gate_high_c_o, // phase c high gate
  output logic gate_low_c_o // phase c low gate
);
  import commut_pkg::*;

  // pattern decode, result packed {c, b, a}
  function automatic logic [5:0] pattern_map(input logic [2:0] code, input logic step);
    logic [5:0] r;
    r = {PH_OFF, PH_OFF, PH_OFF};
    if (!step)
    begin
      unique case (code)
        3'h3: r = {PH_OFF, PH_LON, PH_PWM};
        3'h2: r = {PH_PWM, PH_LON, PH_OFF};
        3'h6: r = {PH_PWM, PH_OFF, PH_LON};
        3'h4: r = {PH_OFF, PH_PWM, PH_LON};
        3'h5: r = {PH_LON, PH_PWM, PH_OFF};
        3'h1: r = {PH_LON, PH_OFF, PH_PWM};
        3'h7: r = {PH_LON, PH_LON, PH_PWM};
        3'h0: r = {PH_OFF, PH_OFF, PH_OFF};
      endcase
    end
    else
    begin
      unique case (code)
        3'h2: r = {PH_PWM, PH_LON, PH_PWM};
        3'h6: r = {PH_PWM, PH_LON, PH_LON};
        3'h4: r = {PH_PWM, PH_PWM, PH_LON};
        3'h5: r = {PH_LON, PH_PWM, PH_LON};
        3'h1: r = {PH_LON, PH_PWM, PH_PWM};
        3'h3: r = {PH_LON, PH_LON, PH_PWM};
        3'h7: r = {PH_LON, PH_LON, PH_PWM};
        3'h0: r = {PH_OFF, PH_OFF, PH_OFF};
      endcase
    end
    return r;
  endfunction : pattern_map

  // hall decode, result packed {c, b, a}
  function automatic logic [5:0] hall_map(input logic [2:0] code, input logic dir);
    logic [5:0] r;
    r = {PH_OFF, PH_OFF, PH_OFF};
    unique case ({dir, code})
      4'hD: r = {PH_LON, PH_OFF, PH_PWM};
      4'hC: r = {PH_LON, PH_PWM, PH_OFF};
      4'hE: r = {PH_OFF, PH_PWM, PH_LON};
      4'hA: r = {PH_PWM, PH_OFF, PH_LON};
      4'hB: r = {PH_PWM, PH_LON, PH_OFF};
      4'h9: r = {PH_OFF, PH_LON, PH_PWM};
      4'h5: r = {PH_PWM, PH_OFF, PH_LON};
      4'h4: r = {PH_PWM, PH_LON, PH_OFF};
      4'h6: r = {PH_OFF, PH_LON, PH_PWM};
      4'h2: r = {PH_LON, PH_OFF, PH_PWM};
      4'h3: r = {PH_LON, PH_PWM, PH_OFF};
      4'h1: r = {PH_OFF, PH_PWM, PH_LON};
      default: r = {PH_OFF, PH_OFF, PH_OFF}; // forbidden 000 / 111
    endcase
    return r;
  endfunction : hall_map

  logic [SYNC_W-1:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
  logic [2:0] mode_ff, nxt_mode;
  logic recirc_ff, nxt_recirc;
  logic [1:0] brake_style_ff, nxt_brake_style;
  logic [DT_W-1:0] deadtime_rising_ff, nxt_deadtime_rising;
  logic [DT_W-1:0] dt_fall_ff, nxt_dt_fall;
  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic brake_prev_ff, nxt_brake_prev;
  logic alt_ff, nxt_alt;
  logic brake_s, brake_event, pwm_s;
  logic [2:0] pat_code, hall_code;
  logic [5:0] ph_state;
  logic [2:0] pwm_mask, raw_hi, raw_lo, hi_q, lo_q;
  logic bus_req;

  // input synchroniser; only the second stage feeds the decoder
  always_comb
  begin
    nxt_sync1 = {brake_request_n_i, step_direction_input_i, aux_input_4_i,
                 aux_input_3_i, aux_input_2_i, aux_input_1_i,
                 duty_reference_input_i};
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
    end
    else
    begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // wishbone slave: ack one cycle after the strobe, dropped next cycle
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;

  always_comb
  begin
    nxt_ack = bus_req;
    nxt_mode = mode_ff;
    nxt_recirc = recirc_ff;
    nxt_brake_style = brake_style_ff;
    nxt_deadtime_rising = deadtime_rising_ff;
    nxt_dt_fall = dt_fall_ff;
    nxt_rdata = 32'h0000_0000;
    if (bus_req && wb_we_i)
    begin
      if (wb_adr_i == CTRL_OFS && wb_sel_i[0])
      begin
        nxt_mode = wb_dat_i[MODE_LSB +: 3];
        nxt_recirc = wb_dat_i[RECIRC_BIT];
        nxt_brake_style = wb_dat_i[BRAKE_LSB +: 2];
      end
      if (wb_adr_i == DEADTIME_OFS && wb_sel_i[0])
      begin
        nxt_deadtime_rising = wb_dat_i[DEADTIME_RISING_LSB +: DT_W];
      end
      if (wb_adr_i == DEADTIME_OFS && wb_sel_i[1])
      begin
        nxt_dt_fall = wb_dat_i[DT_FALL_LSB +: DT_W];
      end
    end
    if (bus_req && !wb_we_i)
    begin
      if (wb_adr_i == CTRL_OFS)
      begin
        nxt_rdata[MODE_LSB +: 3] = mode_ff;
        nxt_rdata[RECIRC_BIT] = recirc_ff;
        nxt_rdata[BRAKE_LSB +: 2] = brake_style_ff;
      end
      else if (wb_adr_i == DEADTIME_OFS)
      begin
        nxt_rdata[DEADTIME_RISING_LSB +: DT_W] = deadtime_rising_ff;
        nxt_rdata[DT_FALL_LSB +: DT_W] = dt_fall_ff;
      end
      else if (wb_adr_i == STATUS_OFS)
      begin
        nxt_rdata[20:0] = {alt_ff, !brake_s, ph_state, lo_q, hi_q, sync2_ff};
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      mode_ff <= MODE_RST;
      recirc_ff <= RECIRC_RST;
      brake_style_ff <= BRAKE_RST;
      deadtime_rising_ff <= DEADTIME_RISING_RST;
      dt_fall_ff <= DT_FALL_RST;
    end
    else
    begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      mode_ff <= nxt_mode;
      recirc_ff <= nxt_recirc;
      brake_style_ff <= nxt_brake_style;
      deadtime_rising_ff <= nxt_deadtime_rising;
      dt_fall_ff <= nxt_dt_fall;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // brake edge tracking; alternate style flips on each new event
  assign brake_s = sync2_ff[IN_BRAKE_N];
  assign brake_event = brake_prev_ff && !brake_s;

  always_comb
  begin
    nxt_brake_prev = brake_s;
    nxt_alt = brake_event ? !alt_ff : alt_ff;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      brake_prev_ff <= 1'b1;
      alt_ff <= ALT_RST;
    end
    else
    begin
      brake_prev_ff <= nxt_brake_prev;
      alt_ff <= nxt_alt;
    end
  end

  // commutation decode
  assign pwm_s = sync2_ff[IN_PWM];
  assign pat_code = {sync2_ff[IN_AUX1], sync2_ff[IN_AUX2], sync2_ff[IN_AUX3]};
  assign hall_code = {sync2_ff[IN_AUX1], sync2_ff[IN_AUX3], sync2_ff[IN_AUX4]};

  always_comb
  begin
    ph_state = {PH_OFF, PH_OFF, PH_OFF};
    if (mode_ff == MODE_PATTERN)
    begin
      ph_state = pattern_map(pat_code, sync2_ff[IN_STEP]);
    end
    else if (mode_ff == MODE_HALL)
    begin
      ph_state = hall_map(hall_code, sync2_ff[IN_STEP]);
    end
    if (!brake_s)
    begin
      unique case (brake_style_ff)
        BRAKE_LOW: ph_state = {PH_LON, PH_LON, PH_LON};
        BRAKE_HIGH: ph_state = {PH_HON, PH_HON, PH_HON};
        BRAKE_ALT: ph_state = nxt_alt ? {PH_HON, PH_HON, PH_HON} : {PH_LON, PH_LON, PH_LON};
        BRAKE_HIZ: ph_state = {PH_OFF, PH_OFF, PH_OFF};
      endcase
    end
  end

  // per-phase gate requests from the decoded phase state
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      pwm_mask[i] = (ph_state[2*i +: 2] == PH_PWM);
      raw_hi[i] = (pwm_mask[i] && pwm_s) || (ph_state[2*i +: 2] == PH_HON);
      raw_lo[i] = (ph_state[2*i +: 2] == PH_LON)
                  || (pwm_mask[i] && !recirc_ff && !pwm_s);
    end
  end

  for (genvar g = 0; g < 3; g++)
  begin : g_phase
    deadtime_gen #(
      .DT_W(DT_W)
    ) u_dt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .hi_req_i(raw_hi[g]),
      .lo_req_i(raw_lo[g]),
      .deadtime_rising_i(deadtime_rising_ff),
      .dt_fall_i(dt_fall_ff),
      .hi_o(hi_q[g]),
      .lo_o(lo_q[g])
    );
  end

  assign gate_high_a_o = hi_q[0];
  assign gate_low_a_o = lo_q[0];
  assign gate_high_b_o = hi_q[1];
  assign gate_low_b_o = lo_q[1];
  assign gate_high_c_o = hi_q[2];
  assign gate_low_c_o = lo_q[2];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_OTHER_MODES_OFF: assert property (
    brake_s && mode_ff != MODE_PATTERN && mode_ff != MODE_HALL |-> ph_state == 6'h00)
    else $error("unsupported mode drives a gate");
  AST_DIODE_LOW_OFF: assert property (
    recirc_ff |-> (raw_lo & pwm_mask) == 3'h0)
    else $error("diode recirculation drove a modulated low side");
  AST_DUTY_FOLLOWS: assert property (
    brake_s |-> (raw_hi & pwm_mask) == ({3{pwm_s}} & pwm_mask))
    else $error("modulated high side does not follow reference");
  AST_AUX4_IGNORED: assert property (
    mode_ff == MODE_PATTERN && $stable(mode_ff) && brake_s
    && $stable({sync2_ff[6:5], sync2_ff[3:1]}) |-> $stable(ph_state))
    else $error("fourth aux input changed pattern state");
  AST_SIX_STEP_AB: assert property (
    mode_ff == MODE_PATTERN && brake_s && pat_code == 3'h3 && !sync2_ff[IN_STEP]
    |-> ph_state == {PH_OFF, PH_LON, PH_PWM})
    else $error("code 011 step low not state AB");
  AST_ADVANCED_C: assert property (
    mode_ff == MODE_PATTERN && brake_s && pat_code == 3'h6 && sync2_ff[IN_STEP]
    |-> ph_state == {PH_PWM, PH_LON, PH_LON})
    else $error("code 110 step high not advanced state");
  AST_STOP: assert property (
    mode_ff == MODE_PATTERN && brake_s && pat_code == 3'h0 |-> raw_hi == 3'h0 && raw_lo == 3'h0)
    else $error("stop code left a high side on");
  AST_ACTIVE_FREEWHEEL: assert property (
    !recirc_ff && brake_s |-> (raw_lo & pwm_mask) == ({3{!pwm_s}} & pwm_mask))
    else $error("active freewheel low side not inverted");
  AST_BRAKE_LOW: assert property (
    !brake_s && brake_style_ff == BRAKE_LOW |-> raw_lo == 3'h7 && raw_hi == 3'h0)
    else $error("low side brake not applied");
  AST_BRAKE_ALT: assert property (
    brake_event && brake_style_ff == BRAKE_ALT |=> alt_ff != $past(alt_ff))
    else $error("alternate brake did not flip");
  AST_HALL_FWD: assert property (
    mode_ff == MODE_HALL && brake_s && hall_code == 3'h5 && sync2_ff[IN_STEP]
    |-> ph_state == {PH_LON, PH_OFF, PH_PWM})
    else $error("hall 101 forward wrong");
  AST_HALL_FORBID: assert property (
    mode_ff == MODE_HALL && brake_s && (hall_code == 3'h7 || hall_code == 3'h0)
    |-> ph_state == 6'h00)
    else $error("forbidden hall code drove a gate");
  AST_NO_OVERLAP: assert property (
    $rose(hi_q[0]) |-> !lo_q[0] && $past(lo_q[0]) == 1'b0)
    else $error("phase a high gate rose against low gate");
  AST_SYNC_DELAY: assert property (
    mode_ff == MODE_HALL && $stable(mode_ff) |-> hall_code == {$past(aux_input_1_i, 2),
    $past(aux_input_3_i, 2), $past(aux_input_4_i, 2)})
    else $error("hall code not two cycles behind pins");

  COV_BRAKE_ALT: cover property (brake_event && brake_style_ff == BRAKE_ALT);
  COV_HALL_RUN: cover property (mode_ff == MODE_HALL && hi_q[0] && lo_q[2]);
  COV_TWELVE_STEP: cover property (mode_ff == MODE_PATTERN && $changed(sync2_ff[IN_STEP]));
endmodule : commutation_logic
`default_nettype wire

// ===== rtl/commut_pkg.sv
package commut_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DEADTIME_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  // control field positions
  localparam int MODE_LSB = 0;
  localparam int RECIRC_BIT = 3;
  localparam int BRAKE_LSB = 4;
  localparam int DEADTIME_RISING_LSB = 0;
  localparam int DT_FALL_LSB = 8;
  // drive_mode_select codes
  localparam logic [2:0] MODE_PATTERN = 3'h2;
  localparam logic [2:0] MODE_HALL = 3'h3;
  // brake styles
  localparam logic [1:0] BRAKE_LOW = 2'h0;
  localparam logic [1:0] BRAKE_HIGH = 2'h1;
  localparam logic [1:0] BRAKE_ALT = 2'h2;
  localparam logic [1:0] BRAKE_HIZ = 2'h3;
  // reset values
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic RECIRC_RST = 1'b1;
  localparam logic [1:0] BRAKE_RST = 2'h0;
  localparam logic [7:0] DEADTIME_RISING_RST = 8'h04;
  localparam logic [7:0] DT_FALL_RST = 8'h04;
  localparam logic ALT_RST = 1'b1;
  // synchronised input vector positions
  localparam int IN_PWM = 0;
  localparam int IN_AUX1 = 1;
  localparam int IN_AUX2 = 2;
  localparam int IN_AUX3 = 3;
  localparam int IN_AUX4 = 4;
  localparam int IN_STEP = 5;
  localparam int IN_BRAKE_N = 6;
  localparam int SYNC_W = 7;
  localparam logic [6:0] SYNC_RST = 7'h40;
  typedef enum logic [1:0] {
    PH_OFF = 2'b00,
    PH_PWM = 2'b01,
    PH_LON = 2'b10,
    PH_HON = 2'b11
  } phase_e;
endpackage : commut_pkg

// ===== rtl/deadtime_gen.sv
`timescale 1ns/100ps
`default_nettype none
module deadtime_gen #(
  parameter int DT_W = 8
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, high
  input wire logic hi_req_i, // requested high side
  input wire logic lo_req_i, // requested low side
  input wire logic [DT_W-1:0] deadtime_rising_i, // wait before high on
  input wire logic [DT_W-1:0] dt_fall_i, // wait before low on
  output logic hi_o, // high gate
  output logic lo_o // low gate
);
  logic hi_ff, lo_ff, nxt_hi, nxt_lo;
  logic [DT_W-1:0] hcnt_ff, lcnt_ff, nxt_hcnt, nxt_lcnt;

  // a side only counts once the opposite gate is seen off, so the
  // two gates can never overlap even with a zero setting
  always_comb
  begin
    nxt_hcnt = '0;
    nxt_lcnt = '0;
    if (hi_req_i && !lo_ff)
    begin
      nxt_hcnt = (hcnt_ff == '1) ? hcnt_ff : hcnt_ff + 1'b1;
    end
    if (lo_req_i && !hi_ff)
    begin
      nxt_lcnt = (lcnt_ff == '1) ? lcnt_ff : lcnt_ff + 1'b1;
    end
    nxt_hi = hi_req_i && !lo_ff && (hcnt_ff >= deadtime_rising_i);
    nxt_lo = lo_req_i && !hi_ff && (lcnt_ff >= dt_fall_i);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hi_ff <= 1'b0;
      lo_ff <= 1'b0;
      hcnt_ff <= '0;
      lcnt_ff <= '0;
    end
    else
    begin
      hi_ff <= nxt_hi;
      lo_ff <= nxt_lo;
      hcnt_ff <= nxt_hcnt;
      lcnt_ff <= nxt_lcnt;
    end
  end

  assign hi_o = hi_ff;
  assign lo_o = lo_ff;
endmodule : deadtime_gen
`default_nettype wire

// ===== tb/ctrl_hall_model.sv
`timescale 1ns/100ps
`default_nettype none
module ctrl_hall_model (
  input wire logic hall_i, // sensor mapping when high
  input wire logic [2:0] code_i, // pattern or sensor code
  input wire logic step_i, // 12-step or direction
  input wire logic pwm_i, // modulation reference
  input wire logic aux4_i, // spare pin level, pattern mode
  input wire logic brake_n_i, // brake request, low active
  output logic pwm_o, // duty reference pin
  output logic aux1_o, // aux pin 1
  output logic aux2_o, // aux pin 2
  output logic aux3_o, // aux pin 3
  output logic aux4_o, // aux pin 4
  output logic step_o, // step or direction pin
  output logic brake_n_o // brake pin
);
  always_comb
  begin
    pwm_o = pwm_i;
    step_o = step_i; // bench toggles it once per 30-degree step
    brake_n_o = brake_n_i;
    aux1_o = code_i[2];
    if (hall_i)
    begin
      // unused pin keeps moving so a decoder that reads it shows up
      aux2_o = ~pwm_i;
      aux3_o = code_i[1];
      aux4_o = code_i[0]; // forbidden codes only when commanded
    end
    else
    begin
      aux2_o = code_i[1];
      aux3_o = code_i[0];
      aux4_o = aux4_i; // held low unless a scenario says otherwise
    end
  end
endmodule : ctrl_hall_model
`default_nettype wire

// ===== tb/single_input_commutation_logic_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(w, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("Error %s expected %0h seen %0h", w, e, g); \
    end \
  end
module single_input_commutation_logic_tb;
  import commut_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic hall = 0, step = 0, pwm = 0, brk_n = 1, aux4 = 0;
  logic [2:0] code = 0;
  logic cyc = 0, stb = 0, we = 0, ack;
  logic [7:0] adr = 0;
  logic [31:0] wdat = 0, dat_o, q;
  logic p_pwm, p_a1, p_a2, p_a3, p_a4, p_step, p_brk;
  logic ha, la, hb, lb, hc, lc;
  logic [5:0] gates;
  int errors = 0;
  int cmp_count = 0;
  // phase words {a,b,c}: 0 off, 1 modulated, 2 low side on
  logic [5:0] pt0 [8] = '{6'h00, 6'h12, 6'h09, 6'h18, 6'h24, 6'h06, 6'h21, 6'h1A};
  logic [5:0] pt1 [8] = '{6'h00, 6'h16, 6'h19, 6'h1A, 6'h25, 6'h26, 6'h29, 6'h1A};
  logic [5:0] hl1 [8] = '{6'h00, 6'h18, 6'h21, 6'h09, 6'h06, 6'h12, 6'h24, 6'h00};
  logic [5:0] hl0 [8] = '{6'h00, 6'h24, 6'h12, 6'h06, 6'h09, 6'h21, 6'h18, 6'h00};
  logic [2:0] seq [14] = '{3'h3, 3'h2, 3'h2, 3'h6, 3'h6, 3'h4, 3'h4, 3'h5, 3'h5, 3'h1, 3'h1,
    3'h3, 3'h7, 3'h0};
  assign gates = {ha, la, hb, lb, hc, lc};
  initial forever #4 clk = ~clk;
  ctrl_hall_model ctrl_hall_model_inst (.hall_i(hall), .code_i(code), .step_i(step),
    .pwm_i(pwm), .aux4_i(aux4), .brake_n_i(brk_n), .pwm_o(p_pwm), .aux1_o(p_a1),
    .aux2_o(p_a2), .aux3_o(p_a3), .aux4_o(p_a4), .step_o(p_step), .brake_n_o(p_brk));
  commutation_logic commutation_logic_inst (.clk_i(clk), .rst_i(rst),
    .duty_reference_input_i(p_pwm), .aux_input_1_i(p_a1), .aux_input_2_i(p_a2),
    .aux_input_3_i(p_a3), .aux_input_4_i(p_a4), .step_direction_input_i(p_step),
    .brake_request_n_i(p_brk), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .gate_high_a_o(ha), .gate_low_a_o(la), .gate_high_b_o(hb), .gate_low_b_o(lb),
    .gate_high_c_o(hc), .gate_low_c_o(lc));
  function automatic logic [5:0] exp_gates(input logic [5:0] ph, input logic p,
    input logic act);
    logic [5:0] g;
    logic [1:0] st;
    for (int k = 0; k < 3; k++)
    begin
      st = ph[5-2*k -: 2];
      g[5-2*k] = (st == 2'd1) & p;
      g[4-2*k] = (st == 2'd2) | ((st == 2'd1) & act & ~p);
    end
    return g;
  endfunction : exp_gates
  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = dat_o;
    if (n >= 20)
      errors++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic ctrl(input logic [2:0] m, input logic r, input logic [1:0] b);
    wb(1'b1, CTRL_OFS, {26'h0, b, r, m});
  endtask : ctrl
  task automatic settle;
    // covers sync stages plus off, reset dead time and on
    repeat (14) @(posedge clk);
    #1;
  endtask : settle
  task automatic put(input logic h, input logic [2:0] c, input logic s, input logic p);
    @(posedge clk);
    hall <= h;
    code <= c;
    step <= s;
    pwm <= p;
    settle();
  endtask : put
  task automatic one(input logic h, input logic [2:0] c, input logic s, input logic act);
    logic [5:0] ph;
    ph = h ? (s ? hl1[c] : hl0[c]) : (s ? pt1[c] : pt0[c]);
    put(h, c, s, 1'b1);
    `CHK("gates pwm high", exp_gates(ph, 1'b1, act), gates);
    put(h, c, s, 1'b0);
    `CHK("gates pwm low", exp_gates(ph, 1'b0, act), gates);
  endtask : one
  task automatic t_regs;
    wb(1'b0, CTRL_OFS, 32'h0);
    `CHK("ctrl reset", 32'h8, q);
    wb(1'b0, DEADTIME_OFS, 32'h0);
    `CHK("deadtime reset", 32'h0404, q);
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h0C, 32'h0);
    `CHK("unmapped", 32'h0, q);
    wb(1'b1, STATUS_OFS, 32'hFFFF_FFFF);
    wb(1'b0, STATUS_OFS, 32'h0);
    `CHK("status", 32'h0010_0040, q);
    $display("test regs done");
  endtask : t_regs
  task automatic t_modes;
    for (int m = 0; m < 8; m++)
      if (m != 2 && m != 3)
      begin
        ctrl(m[2:0], 1'b1, BRAKE_LOW);
        put(1'b0, 3'h3, 1'b0, 1'b1);
        `CHK("other mode", 6'h00, gates);
      end
    $display("test modes done");
  endtask : t_modes
  task automatic t_pattern(input logic act, input logic a4);
    @(posedge clk);
    aux4 <= a4;
    ctrl(MODE_PATTERN, ~act, BRAKE_LOW);
    for (int i = 0; i < 14; i++)
      one(1'b0, seq[i], i[0], act);
    @(posedge clk);
    aux4 <= 1'b0;
    $display("test pattern done");
  endtask : t_pattern
  task automatic t_hall(input logic act);
    ctrl(MODE_HALL, ~act, BRAKE_LOW);
    for (int i = 0; i < 16; i++)
      one(1'b1, i[2:0], i[3], act);
    $display("test hall done");
  endtask : t_hall
  task automatic brake_evt(input logic [5:0] e);
    @(posedge clk);
    brk_n <= 1'b0;
    settle();
    `CHK("brake gates", e, gates);
    @(posedge clk);
    brk_n <= 1'b1;
    settle();
  endtask : brake_evt
  task automatic t_brake;
    put(1'b0, 3'h3, 1'b0, 1'b1);
    ctrl(MODE_PATTERN, 1'b1, BRAKE_LOW);
    brake_evt(6'h15);
    ctrl(MODE_PATTERN, 1'b1, BRAKE_HIGH);
    brake_evt(6'h2A);
    ctrl(MODE_PATTERN, 1'b1, BRAKE_HIZ);
    brake_evt(6'h00);
    ctrl(MODE_HALL, 1'b1, BRAKE_HIGH);
    put(1'b1, 3'h1, 1'b1, 1'b1);
    brake_evt(6'h2A);
    // fresh reset so the alternate flag starts from its reset value
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    ctrl(MODE_PATTERN, 1'b1, BRAKE_ALT);
    brake_evt(6'h15);
    brake_evt(6'h2A);
    $display("test brake done");
  endtask : t_brake
  task automatic t_dt;
    int n;
    wb(1'b1, DEADTIME_OFS, 32'h0006);
    ctrl(MODE_HALL, 1'b1, BRAKE_LOW);
    put(1'b1, 3'h0, 1'b0, 1'b1);
    @(posedge clk);
    code <= 3'h5;
    repeat (8) @(posedge clk);
    #1;
    `CHK("high c early", 1'b0, hc);
    `CHK("low a", 1'b1, la);
    for (n = 0; n < 12 && hc !== 1'b1; n++)
      @(posedge clk);
    #1;
    `CHK("high c late", 1'b1, hc);
    $display("test deadtime done");
  endtask : t_dt
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_modes();
    t_pattern(1'b0, 1'b1);
    t_pattern(1'b1, 1'b0);
    t_hall(1'b0);
    t_hall(1'b1);
    t_brake();
    t_dt();
    complete_run();
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    errors++;
    complete_run();
  end
endmodule : single_input_commutation_logic_tb
`default_nettype wire
